// [flash_param_host.sv]
// host controller: fetches the parameter words and decodes them for software
//
// Local design decisions: the APB register port and the address map.
module flash_param_host (
  input  wire logic        core_clk_i,
  input  wire logic        rst_b_i,
  flash_link_if.host       link,
  input  wire logic [7:0]  paddr_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o
);
  `include "flash_param_defs.svh"

  flash_param_pkg::host_st_t s_r;
  flash_param_pkg::host_st_t s_nxt;
  logic [3:0]                io_sync;

  pin_sync #(
    .W(4)
  ) u_io_sync (
    .clk_i  (core_clk_i),
    .rst_b_i(rst_b_i),
    .d_i    (link.io),
    .q_o    (io_sync)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // decoding of fetched words

  // unsupported reads report zero; turnaround is counted in clocks
  function automatic logic [31:0] plan(input logic [31:0] w, input logic sup);
    logic [5:0] turn;
    turn = 6'(w[`FP_MODE_FLD]) + 6'(w[`FP_DUMMY_FLD]);
    return sup ? {w[31:16], 10'h000, turn} : 32'h0000_0000;
  endfunction

  // region size 2^N; zero means absent, exponents past the word width saturate
  function automatic logic [31:0] erase_bytes(input logic [7:0] n);
    if (n == `FP_SIZE_ABSENT) begin
      return 32'h0000_0000;
    end
    if (n > 8'h1F) begin
      return 32'hFFFF_FFFF;
    end
    return 32'h0000_0001 << n[4:0];
  endfunction

  // an absent type exposes no opcode, so software never issues it
  function automatic logic [7:0] erase_op(input logic [7:0] op, input logic [7:0] n);
    return (n == `FP_SIZE_ABSENT) ? 8'h00 : op;
  endfunction

  function automatic logic [32:0] reg_read(
    input logic [7:0]  a,
    input flash_param_pkg::host_st_t st
  );
    logic [32:0] r;
    r = {1'b0, 32'h0000_0000};
    case (a)
      `FP_REG_CTRL:      r[31:0] = 32'h0000_0000;
      `FP_REG_STATUS:    r[31:0] = {30'h0, st.done, st.busy};
      `FP_REG_RAW5:      r[31:0] = st.words[0];
      `FP_REG_RAW6:      r[31:0] = st.words[1];
      `FP_REG_RAW7:      r[31:0] = st.words[2];
      `FP_REG_RAW8:      r[31:0] = st.words[3];
      `FP_REG_RAW9:      r[31:0] = st.words[4];
      `FP_REG_DUAL_PLAN: r[31:0] = plan(st.words[1], st.words[0][`FP_DUAL_SUP_BIT]);
      `FP_REG_QUAD_PLAN: r[31:0] = plan(st.words[2], st.words[0][`FP_QUAD_SUP_BIT]);
      `FP_REG_ERASE1_B:  r[31:0] = erase_bytes(st.words[3][`FP_LO_SIZE]);
      `FP_REG_ERASE2_B:  r[31:0] = erase_bytes(st.words[3][`FP_HI_SIZE]);
      `FP_REG_ERASE3_B:  r[31:0] = erase_bytes(st.words[4][`FP_LO_SIZE]);
      `FP_REG_ERASE4_B:  r[31:0] = erase_bytes(st.words[4][`FP_HI_SIZE]);
      `FP_REG_ERASE_OPS: begin
        r[31:0] = {erase_op(st.words[4][`FP_HI_OP], st.words[4][`FP_HI_SIZE]),
                   erase_op(st.words[4][`FP_LO_OP], st.words[4][`FP_LO_SIZE]),
                   erase_op(st.words[3][`FP_HI_OP], st.words[3][`FP_HI_SIZE]),
                   erase_op(st.words[3][`FP_LO_OP], st.words[3][`FP_LO_SIZE])};
      end
      default:           r = {1'b1, 32'h0000_0000};
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // apb slave, link clock divider and frame sequencer

  localparam logic [5:0] ADDR_LAST  = `FP_OPC_BITS + `FP_ADDR_BITS - 6'd1;
  localparam logic [5:0] MODE_LAST  = ADDR_LAST + `FP_MODE_CLKS;
  localparam logic [5:0] DUMMY_LAST = MODE_LAST + `FP_DUMMY_CLKS;
  localparam logic [5:0] DATA_LAST  = DUMMY_LAST + `FP_DATA_BITS;

  always_comb begin
    logic [32:0] rd;
    logic [15:0] hdr;
    s_nxt       = s_r;
    rd          = reg_read(paddr_i, s_r);
    hdr         = {`FP_TBL_READ_OP, `FP_WORD_SUPPORT + {5'h00, s_r.widx}};
    s_nxt.phase = s_r.phase + 3'h1;
    s_nxt.sclk  = s_nxt.phase[2];
    s_nxt.ack   = 1'b0;
    // read data is registered, so every access takes one wait cycle
    if (psel_i && penable_i && !s_r.ack) begin
      s_nxt.ack     = 1'b1;
      s_nxt.prdata  = rd[31:0];
      s_nxt.pslverr = rd[32];
    end
    if (psel_i && penable_i && s_r.ack && pwrite_i && paddr_i == `FP_REG_CTRL &&
        pwdata_i[`FP_CTRL_START] && !s_r.busy) begin
      s_nxt.busy = 1'b1;
      s_nxt.done = 1'b0;
      s_nxt.widx = 3'h0;
    end
    if (s_r.state == flash_param_pkg::H_DATA && s_r.phase == `FP_PH_SAMPLE) begin
      s_nxt.rx = {s_r.rx[30:0], io_sync[`FP_DATA_LANE]};
    end
    if (s_r.phase == `FP_PH_DRIVE) begin
      s_nxt.cnt = s_r.cnt + 6'h01;
      unique case (s_r.state)
        flash_param_pkg::H_IDLE: begin
          if (s_r.busy && s_r.widx == `FP_FETCH_WORDS) begin
            s_nxt.busy = 1'b0;
            s_nxt.done = 1'b1;
          end else if (s_r.busy) begin
            s_nxt.cs_b  = 1'b0;
            s_nxt.cnt   = 6'h00;
            s_nxt.tx    = {hdr[14:0], 1'b0};
            s_nxt.io_o  = {3'h0, hdr[15]};
            s_nxt.io_oe = 4'h1;
            s_nxt.state = flash_param_pkg::H_OPC;
          end
        end
        flash_param_pkg::H_OPC: begin
          if (s_r.cnt == ADDR_LAST) begin
            // mode clocks: lanes stay driven by this end
            s_nxt.io_o  = `FP_MODE_PATTERN;
            s_nxt.io_oe = 4'hF;
            s_nxt.state = flash_param_pkg::H_MODE;
          end else begin
            s_nxt.io_o  = {3'h0, s_r.tx[15]};
            s_nxt.tx    = {s_r.tx[14:0], 1'b0};
          end
        end
        flash_param_pkg::H_MODE: begin
          if (s_r.cnt == MODE_LAST) begin
            s_nxt.io_oe = 4'h0;
            s_nxt.state = flash_param_pkg::H_DUMMY;
          end
        end
        flash_param_pkg::H_DUMMY: begin
          if (s_r.cnt == DUMMY_LAST) begin
            s_nxt.state = flash_param_pkg::H_DATA;
          end
        end
        flash_param_pkg::H_DATA: begin
          if (s_r.cnt == DATA_LAST) begin
            s_nxt.cs_b            = 1'b1;
            s_nxt.words[s_r.widx] = s_r.rx;
            s_nxt.widx            = s_r.widx + 3'h1;
            s_nxt.state           = flash_param_pkg::H_GAP;
          end
        end
        flash_param_pkg::H_GAP: begin
          s_nxt.state = flash_param_pkg::H_IDLE;
        end
        default: begin
          s_nxt.state = flash_param_pkg::H_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      s_r      <= '0;
      s_r.cs_b <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.sclk       = s_r.sclk;
  assign link.cs_b       = s_r.cs_b;
  assign link.host_io_o  = s_r.io_o;
  assign link.host_io_oe = s_r.io_oe;
  assign prdata_o        = s_r.prdata;
  assign pready_o        = s_r.ack;
  assign pslverr_o       = s_r.pslverr & s_r.ack;
endmodule // flash_param_host

// [flash_param_defs.svh]
// constants shared by the parameter-table device, its host controller and the link
`ifndef FLASH_PARAM_DEFS_SVH
`define FLASH_PARAM_DEFS_SVH

////////////////////////////////////////////////////////////////////////////////
// link frame layout, counted in link clock periods
`define FP_TBL_READ_OP   8'hA7
`define FP_OPC_BITS      6'd8
`define FP_ADDR_BITS     6'd8
`define FP_MODE_CLKS     6'd2
`define FP_DUMMY_CLKS    6'd2
`define FP_DATA_BITS     6'd32
`define FP_MODE_PATTERN  4'hF
`define FP_DATA_LANE     1

////////////////////////////////////////////////////////////////////////////////
// link clock divider: core clock / 8, phases of a 3-bit counter
`define FP_PH_DRIVE      3'h7
`define FP_PH_SAMPLE     3'h2

////////////////////////////////////////////////////////////////////////////////
// parameter word numbers and field positions
`define FP_WORD_SUPPORT  8'h05
`define FP_WORD_DUAL     8'h06
`define FP_WORD_QUAD     8'h07
`define FP_WORD_ERASE12  8'h08
`define FP_WORD_ERASE34  8'h09
`define FP_FETCH_WORDS   3'h5
`define FP_DUAL_SUP_BIT  0
`define FP_QUAD_SUP_BIT  4
`define FP_HI_OP         31:24
`define FP_MODE_FLD      23:21
`define FP_DUMMY_FLD     20:16
`define FP_HI_SIZE       23:16
`define FP_LO_OP         15:8
`define FP_LO_SIZE       7:0
`define FP_RSVD_LOW      15:0

////////////////////////////////////////////////////////////////////////////////
// table contents
`define FP_SUPPORT_RSVD  32'hFFFF_FFEE
`define FP_RSVD_ONES     16'hFFFF
`define FP_UNUSED_WORD   32'hFFFF_FFFF
`define FP_DUAL_OP       8'h3C
`define FP_DUAL_MODE     3'h1
`define FP_DUAL_DUMMY    5'h04
`define FP_QUAD_OP       8'h6E
`define FP_QUAD_MODE     3'h1
`define FP_QUAD_DUMMY    5'h06
`define FP_NO_MODE       3'h0
`define FP_NO_DUMMY      5'h00
`define FP_ERASE1_OP     8'h21
`define FP_ERASE1_SIZE   8'h0C
`define FP_ERASE2_OP     8'h53
`define FP_ERASE2_SIZE   8'h0F
`define FP_ERASE3_OP     8'hD9
`define FP_ERASE3_SIZE   8'h10
`define FP_ERASE4_OP     8'hDC
`define FP_ERASE4_SIZE   8'h00
`define FP_SIZE_ABSENT   8'h00

////////////////////////////////////////////////////////////////////////////////
// apb register byte offsets of the host controller
`define FP_REG_CTRL      8'h00
`define FP_REG_STATUS    8'h04
`define FP_REG_RAW5      8'h08
`define FP_REG_RAW6      8'h0C
`define FP_REG_RAW7      8'h10
`define FP_REG_RAW8      8'h14
`define FP_REG_RAW9      8'h18
`define FP_REG_DUAL_PLAN 8'h1C
`define FP_REG_QUAD_PLAN 8'h20
`define FP_REG_ERASE1_B  8'h24
`define FP_REG_ERASE2_B  8'h28
`define FP_REG_ERASE3_B  8'h2C
`define FP_REG_ERASE4_B  8'h30
`define FP_REG_ERASE_OPS 8'h34
`define FP_CTRL_START    0
`define FP_STAT_BUSY     0
`define FP_STAT_DONE     1

`endif

// [flash_param_pkg.sv]
// types shared by the parameter-table device and its host controller
package flash_param_pkg;

  typedef enum logic [2:0] {
    DEV_IDLE = 3'b000,
    DEV_CMD  = 3'b001,
    DEV_TURN = 3'b011,
    DEV_SEND = 3'b010,
    DEV_DONE = 3'b110
  } dev_state_t;

  typedef enum logic [2:0] {
    H_IDLE  = 3'b000,
    H_OPC   = 3'b001,
    H_MODE  = 3'b011,
    H_DUMMY = 3'b010,
    H_DATA  = 3'b110,
    H_GAP   = 3'b111
  } host_state_t;

  typedef struct packed {
    dev_state_t  state;
    logic [5:0]  cnt;
    logic [15:0] rx;
    logic [7:0]  widx;
    logic [31:0] tx;
    logic [4:0]  bit_left;
    logic        oe;
    logic [7:0]  sent;
    logic        bad;
  } dev_st_t;

  typedef struct packed {
    logic [2:0]       phase;
    logic             sclk;
    logic             cs_b;
    host_state_t      state;
    logic [5:0]       cnt;
    logic [15:0]      tx;
    logic [31:0]      rx;
    logic [2:0]       widx;
    logic [4:0][31:0] words;
    logic             busy;
    logic             done;
    logic [3:0]       io_o;
    logic [3:0]       io_oe;
    logic             ack;
    logic [31:0]      prdata;
    logic             pslverr;
  } host_st_t;

endpackage

// [flash_link_if.sv]
// serial link between the parameter-table device and its host controller
interface flash_link_if;
  logic       sclk;
  logic       cs_b;
  logic [3:0] host_io_o;
  logic [3:0] host_io_oe;
  logic [3:0] dev_io_o;
  logic [3:0] dev_io_oe;
  logic [3:0] io;

  // undriven lanes float high, as with a weak pull-up
  assign io = (host_io_oe & host_io_o) | (dev_io_oe & dev_io_o) | ~(host_io_oe | dev_io_oe);

  modport host (
    output sclk,
    output cs_b,
    output host_io_o,
    output host_io_oe,
    input  io
  );

  modport device (
    input  sclk,
    input  cs_b,
    input  io,
    output dev_io_o,
    output dev_io_oe
  );
endinterface

// [pin_sync.sv]
// two-flop synchroniser for levels entering a clock domain
module pin_sync #(
  parameter int W = 4
) (
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_st_t;

  sync_st_t s_r;
  sync_st_t s_nxt;

  always_comb begin
    s_nxt    = s_r;
    s_nxt.s1 = d_i;
    s_nxt.s2 = s_r.s1;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q_o = s_r.s2;
endmodule // pin_sync

// [flash_param_dev.sv]
// parameter-table device: answers table reads on the serial link
//
// Overview of operation
// - word six top byte: dual all-lane opcode
// - mode-clock field zero without mode bits
// - mode count is in clocks, not bits
// - host drives mode cycles, releases dummy cycles
// - dummy field zero without wait states
// - advertised dummy count kept nonzero; a disabled read advertises zero
// - low halves of words six, seven read ones
// - word seven: quad opcode, mode, dummy
// - 4k erase listed in an erase slot
// - word eight: type-2 opcode and size high
// - word eight: type-1 opcode and size low
// - erase size byte is exponent of two
// - size zero marks erase type absent
// - word nine: type-4 opcode and size high
// - word nine: type-3 opcode and size low
// - support flags gate use of read fields
module flash_param_dev (
  input  wire logic  link_clk_i,
  input  wire logic  rst_b_i,
  flash_link_if.device link,
  input  wire logic  dual_enable_i,
  input  wire logic  quad_enable_i,
  output logic       frame_active_o,
  output logic       bad_cmd_o,
  output logic [7:0] last_word_o,
  output logic [7:0] words_sent_o
);
  `include "flash_param_defs.svh"

  flash_param_pkg::dev_st_t s_r;
  flash_param_pkg::dev_st_t s_nxt;
  logic [1:0]               en_sync;

  ////////////////////////////////////////////////////////////////////////////////
  // strap-like enables come from another domain
  pin_sync #(
    .W(2)
  ) u_en_sync (
    .clk_i  (link_clk_i),
    .rst_b_i(rst_b_i),
    .d_i    ({quad_enable_i, dual_enable_i}),
    .q_o    (en_sync)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // table contents

  // all-lane read word: opcode, mode clocks, dummy clocks, reserved ones
  function automatic logic [31:0] read_word(
    input logic [7:0] op,
    input logic [2:0] mode,
    input logic [4:0] dummy,
    input logic       en
  );
    logic [31:0] w;
    w                = '0;
    w[`FP_HI_OP]     = op;
    // a disabled read advertises neither mode bits nor wait states
    w[`FP_MODE_FLD]  = en ? mode : `FP_NO_MODE;
    w[`FP_DUMMY_FLD] = en ? dummy : `FP_NO_DUMMY;
    w[`FP_RSVD_LOW]  = `FP_RSVD_ONES;
    return w;
  endfunction

  // erase word: two slots of opcode and size exponent
  function automatic logic [31:0] erase_word(
    input logic [7:0] hi_op,
    input logic [7:0] hi_size,
    input logic [7:0] lo_op,
    input logic [7:0] lo_size
  );
    logic [31:0] w;
    w              = '0;
    w[`FP_HI_OP]   = hi_op;
    w[`FP_HI_SIZE] = hi_size;
    w[`FP_LO_OP]   = lo_op;
    w[`FP_LO_SIZE] = lo_size;
    return w;
  endfunction

  // word lookup by number; words outside the implemented span read all ones
  function automatic logic [31:0] table_word(
    input logic [7:0] idx,
    input logic [1:0] en
  );
    logic [31:0] w;
    w = `FP_UNUSED_WORD;
    case (idx)
      `FP_WORD_SUPPORT: begin
        w                   = `FP_SUPPORT_RSVD;
        w[`FP_DUAL_SUP_BIT] = en[0];
        w[`FP_QUAD_SUP_BIT] = en[1];
      end
      `FP_WORD_DUAL: begin
        // dummy constants are nonzero so lane turnaround never overlaps
        w = read_word(`FP_DUAL_OP, `FP_DUAL_MODE, `FP_DUAL_DUMMY, en[0]);
      end
      `FP_WORD_QUAD: begin
        w = read_word(`FP_QUAD_OP, `FP_QUAD_MODE, `FP_QUAD_DUMMY, en[1]);
      end
      `FP_WORD_ERASE12: begin
        // slot one holds the 4k subsector erase
        w = erase_word(`FP_ERASE2_OP, `FP_ERASE2_SIZE,
                       `FP_ERASE1_OP, `FP_ERASE1_SIZE);
      end
      `FP_WORD_ERASE34: begin
        w = erase_word(`FP_ERASE4_OP, `FP_ERASE4_SIZE,
                       `FP_ERASE3_OP, `FP_ERASE3_SIZE);
      end
      default: begin
        w = `FP_UNUSED_WORD;
      end
    endcase
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // frame sequencer, one step per rising link clock edge

  localparam logic [5:0] CMD_LAST  = `FP_OPC_BITS + `FP_ADDR_BITS - 6'd1;
  localparam logic [5:0] TURN_LAST = `FP_OPC_BITS + `FP_ADDR_BITS + `FP_MODE_CLKS
                                     + `FP_DUMMY_CLKS - 6'd1;

  always_comb begin
    logic [7:0] opcode;
    logic [7:0] index;
    logic [7:0] next_idx;
    s_nxt    = s_r;
    opcode   = s_r.rx[14:7];
    index    = {s_r.rx[6:0], link.io[0]};
    next_idx = s_r.widx + 8'h01;
    unique case (s_r.state)
      flash_param_pkg::DEV_IDLE: begin
        s_nxt.rx    = {s_r.rx[14:0], link.io[0]};
        s_nxt.cnt   = 6'h01;
        s_nxt.state = flash_param_pkg::DEV_CMD;
      end
      flash_param_pkg::DEV_CMD: begin
        s_nxt.rx  = {s_r.rx[14:0], link.io[0]};
        s_nxt.cnt = s_r.cnt + 6'h01;
        if (s_r.cnt == CMD_LAST) begin
          if (opcode == `FP_TBL_READ_OP) begin
            s_nxt.widx  = index;
            s_nxt.state = flash_param_pkg::DEV_TURN;
          end else begin
            // unknown command: stay quiet until the frame ends
            s_nxt.bad   = 1'b1;
            s_nxt.state = flash_param_pkg::DEV_DONE;
          end
        end
      end
      flash_param_pkg::DEV_TURN: begin
        // mode clocks are driven by the host and ignored here; the lanes are
        // taken only on the last dummy clock, after the host released them
        s_nxt.cnt = s_r.cnt + 6'h01;
        if (s_r.cnt == TURN_LAST) begin
          s_nxt.tx       = table_word(s_r.widx, en_sync);
          s_nxt.bit_left = 5'h1F;
          s_nxt.oe       = 1'b1;
          s_nxt.state    = flash_param_pkg::DEV_SEND;
        end
      end
      flash_param_pkg::DEV_SEND: begin
        if (s_r.bit_left == 5'h00) begin
          // continuous read: the next word follows until the frame ends
          s_nxt.tx       = table_word(next_idx, en_sync);
          s_nxt.widx     = next_idx;
          s_nxt.bit_left = 5'h1F;
          s_nxt.sent     = s_r.sent + 8'h01;
        end else begin
          s_nxt.tx       = {s_r.tx[30:0], 1'b0};
          s_nxt.bit_left = s_r.bit_left - 5'h01;
        end
      end
      flash_param_pkg::DEV_DONE: begin
        s_nxt.oe = 1'b0;
      end
      default: begin
        s_nxt.state = flash_param_pkg::DEV_IDLE;
      end
    endcase
    // a deselected edge always ends the frame
    if (link.cs_b) begin
      s_nxt.state    = flash_param_pkg::DEV_IDLE;
      s_nxt.cnt      = 6'h00;
      s_nxt.oe       = 1'b0;
      s_nxt.bit_left = 5'h00;
      if (s_r.state == flash_param_pkg::DEV_SEND) begin
        s_nxt.sent = s_r.sent + 8'h01;
      end
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (!rst_b_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // lanes and user status

  // the enable is cut by the frame signal itself, since the link clock may stop
  always_comb begin
    link.dev_io_o                 = 4'h0;
    link.dev_io_oe                = 4'h0;
    link.dev_io_o[`FP_DATA_LANE]  = s_r.tx[31];
    link.dev_io_oe[`FP_DATA_LANE] = s_r.oe & ~link.cs_b;
  end

  assign frame_active_o = (s_r.state != flash_param_pkg::DEV_IDLE);
  assign bad_cmd_o      = s_r.bad;
  assign last_word_o    = s_r.widx;
  assign words_sent_o   = s_r.sent;
endmodule // flash_param_dev

// [flash_link_monitor.sv]
// checker for the wire-level timing of the parameter-table link
module flash_link_monitor (
  input wire logic       core_clk_i,
  input wire logic       rst_b_i,
  input wire logic       cs_b,
  input wire logic [3:0] host_io_o,
  input wire logic [3:0] host_io_oe,
  input wire logic [3:0] dev_io_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] low_cnt_r;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  ////////////////////////////////////////////////////////////////////////////////
  // frame low time in core cycles; a repetition cannot reach 416
  always_ff @(posedge core_clk_i) begin
    low_cnt_r <= cs_b ? 10'h000 : low_cnt_r + 10'h001;
  end

  sequence mode_s;
    (host_io_oe == 4'hF)[*8] ##1 (host_io_oe == 4'hF)[*8];
  endsequence
  sequence dummy_s;
    (host_io_oe == 4'h0 && dev_io_oe == 4'h0)[*8];
  endsequence

  ////////////////////////////////////////////////////////////////////////////////
  chk_no_fight: assert property ((host_io_oe & dev_io_oe) == 4'h0)
    else $error("both ends drive a lane");
  chk_mode_len: assert property (
    $rose(host_io_oe == 4'hF) |-> mode_s ##1 host_io_oe == 4'h0)
    else $error("mode phase length wrong");
  chk_mode_ones: assert property (host_io_oe == 4'hF |-> host_io_o == 4'hF)
    else $error("mode lanes not driven high");
  chk_dummy_gap: assert property (
    $fell(host_io_oe == 4'hF) |-> dummy_s ##[1:24] dev_io_oe == 4'h2)
    else $error("dummy gap or data lane wrong");
  chk_opc_start: assert property (
    $fell(cs_b) |-> (host_io_oe == 4'h1 && host_io_o[0]) ##8 !host_io_o[0] ##8 host_io_o[0])
    else $error("opcode bits wrong");
  chk_frame_len: assert property ($rose(cs_b) |-> low_cnt_r == 10'h1A0)
    else $error("frame length wrong");
  chk_cs_gap: assert property ($rose(cs_b) |-> cs_b[*8])
    else $error("select gap too short");
  chk_idle_quiet: assert property (cs_b |-> dev_io_oe == 4'h0)
    else $error("device drives while deselected");
endmodule // flash_link_monitor

// [flash_param_table_read_erase_tb.sv]
// testbench: host fetches the table from the device, software reads the result
`include "flash_param_defs.svh"
module flash_param_table_read_erase_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, rst_b, dev_rst_b, psel, penable, pwrite, pready, pslverr;
  logic        dual_en, quad_en, frame_act, bad_cmd, bad_b;
  logic [7:0]  paddr, last_word, words_sent;
  logic [31:0] pwdata, prdata;
  int          num_errors, checks, sent;

  flash_link_if lk();
  flash_link_if lk2();
  // device reset outlasts the host's so the device sees link edges in reset
  flash_param_host i_flash_param_host (.core_clk_i(core_clk), .rst_b_i(rst_b), .link(lk),
    .paddr_i(paddr), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr));
  flash_param_dev i_flash_param_dev (.link_clk_i(lk.sclk), .rst_b_i(dev_rst_b), .link(lk),
    .dual_enable_i(dual_en), .quad_enable_i(quad_en), .frame_active_o(frame_act),
    .bad_cmd_o(bad_cmd), .last_word_o(last_word), .words_sent_o(words_sent));
  flash_param_dev i_flash_param_dev_b (.link_clk_i(lk2.sclk), .rst_b_i(dev_rst_b), .link(lk2),
    .dual_enable_i(1'b1), .quad_enable_i(1'b1), .frame_active_o(),
    .bad_cmd_o(bad_b), .last_word_o(), .words_sent_o());
  flash_link_monitor i_flash_link_monitor (.core_clk_i(core_clk), .rst_b_i(rst_b),
    .cs_b(lk.cs_b), .host_io_o(lk.host_io_o), .host_io_oe(lk.host_io_oe),
    .dev_io_oe(lk.dev_io_oe));

  always #50 core_clk = ~core_clk;
  always #6 lk2.sclk = ~lk2.sclk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] x, input logic [7:0] a);
    checks++;
    if (g !== x) begin
      num_errors++;
      $display("[ERR] %0t at %h got %h exp %h", $time, a, g, x);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    @(posedge core_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    // read at the edge itself, before that edge's updates land
    do begin @(posedge core_clk); n++; end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    if (n >= 20) begin
      num_errors++;
      $display("[ERR] %0t bus hang", $time);
      wrap_up();
    end
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] v;
    logic        e;
    apb(1'b0, a, 32'h0, v, e);
    chk(v, x, a);
    chk({31'h0, e}, 32'h0, a);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_fetch(input logic d, input logic q);
    logic [2:0]  m6, m7;
    logic [4:0]  y6, y7;
    logic [31:0] v;
    logic        e;
    int          n;
    dual_en <= d; quad_en <= q;
    repeat (40) @(posedge core_clk);
    m6 = d ? `FP_DUAL_MODE : `FP_NO_MODE;
    y6 = d ? `FP_DUAL_DUMMY : `FP_NO_DUMMY;
    m7 = q ? `FP_QUAD_MODE : `FP_NO_MODE;
    y7 = q ? `FP_QUAD_DUMMY : `FP_NO_DUMMY;
    apb(1'b1, `FP_REG_CTRL, 32'h1, v, e);
    n = 0;
    do begin apb(1'b0, `FP_REG_STATUS, 32'h0, v, e); n++; end while (v[1] !== 1'b1 && n < 1000);
    if (n >= 1000) begin num_errors++; $display("[ERR] %0t fetch hang", $time); wrap_up(); end
    // each frame starts its word and, at the cut, the next one
    sent += 10;
    chk(v, 32'h2, `FP_REG_STATUS);
    rd(`FP_REG_RAW5, `FP_SUPPORT_RSVD | {27'h0, q, 3'h0, d});
    rd(`FP_REG_RAW6, {`FP_DUAL_OP, m6, y6, `FP_RSVD_ONES});
    rd(`FP_REG_RAW7, {`FP_QUAD_OP, m7, y7, `FP_RSVD_ONES});
    rd(`FP_REG_RAW8, {`FP_ERASE2_OP, `FP_ERASE2_SIZE, `FP_ERASE1_OP, `FP_ERASE1_SIZE});
    rd(`FP_REG_RAW9, {`FP_ERASE4_OP, `FP_ERASE4_SIZE, `FP_ERASE3_OP, `FP_ERASE3_SIZE});
    rd(`FP_REG_DUAL_PLAN, d ? {`FP_DUAL_OP, m6, y6, 10'h0, 6'(m6) + 6'(y6)} : 32'h0);
    rd(`FP_REG_QUAD_PLAN, q ? {`FP_QUAD_OP, m7, y7, 10'h0, 6'(m7) + 6'(y7)} : 32'h0);
    // continuous read has already moved one word past the last fetched
    chk({24'h0, last_word}, {24'h0, `FP_WORD_ERASE34 + 8'h01}, 8'hFF);
    chk({24'h0, words_sent}, 32'(sent), 8'hFF);
    chk({31'h0, bad_cmd}, 32'h0, 8'hFF);
    chk({31'h0, frame_act}, 32'h0, 8'hFF);
    $display("test fetch %b%b done", d, q);
  endtask

  task automatic t_regs;
    logic [31:0] v;
    logic        e;
    rd(`FP_REG_ERASE1_B, 32'h1 << `FP_ERASE1_SIZE);
    rd(`FP_REG_ERASE2_B, 32'h1 << `FP_ERASE2_SIZE);
    rd(`FP_REG_ERASE3_B, 32'h1 << `FP_ERASE3_SIZE);
    rd(`FP_REG_ERASE4_B, 32'h0);
    rd(`FP_REG_ERASE_OPS, {8'h00, `FP_ERASE3_OP, `FP_ERASE2_OP, `FP_ERASE1_OP});
    apb(1'b1, `FP_REG_RAW5, 32'h0, v, e);
    rd(`FP_REG_RAW5, `FP_SUPPORT_RSVD);
    rd(`FP_REG_CTRL, 32'h0);
    apb(1'b0, 8'h40, 32'h0, v, e);
    chk({31'h0, e}, 32'h1, 8'h40);
    $display("test regs done");
  endtask

  // foreign opcode into a second device: it must stay silent
  task automatic t_bad_op;
    logic [7:0] op;
    op = 8'h5A;
    @(posedge lk2.sclk);
    lk2.cs_b <= 1'b0; lk2.host_io_oe <= 4'h1;
    for (int i = 7; i >= 0; i--) begin lk2.host_io_o <= {3'h0, op[i]}; @(posedge lk2.sclk); end
    lk2.host_io_oe <= 4'h0;
    repeat (24) begin @(negedge lk2.sclk); chk({28'h0, lk2.dev_io_oe}, 32'h0, 8'hFF); end
    chk({31'h0, bad_b}, 32'h1, 8'hFF);
    @(posedge lk2.sclk);
    lk2.cs_b <= 1'b1;
    $display("test bad opcode done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0; rst_b = 1'b0; dev_rst_b = 1'b0; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0; dual_en = 1'b1; quad_en = 1'b1;
    lk2.sclk = 1'b0; lk2.cs_b = 1'b1; lk2.host_io_o = 4'h0; lk2.host_io_oe = 4'h0;
    num_errors = 0; checks = 0; sent = 0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (30) @(posedge core_clk);
    dev_rst_b <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_fetch(1'b1, 1'b1);
    t_fetch(1'b0, 1'b0);
    t_regs();
    t_bad_op();
    wrap_up();
  end
endmodule // flash_param_table_read_erase_tb
